// ### core/fade_ctrl.sv
/*
  Debounced toggle fade controller: debounce of the active-low enable, toggle latch,
  63-step gamma fade ramp with separate up and down durations.
  Assumes enable is asynchronous; fade times are static straps in milliseconds
  (zero means instant).
*/
`timescale 1ns/100ps
`include "fade_ctrl_defines.svh"
module fade_ctrl #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        enable_n_i,
  input  wire logic        dim_direct_i,
  input  wire logic [11:0] fade_in_time_input_i,
  input  wire logic [11:0] fade_out_time_input_i,
  input  wire logic [9:0]  full_scale_current_input_i,
  output logic             channel_on_o,
  output logic             ramp_busy_o,
  output logic [9:0]       level_o,
  output logic [19:0]      drive_o
);

  localparam logic [20:0] DB_LIMIT = 21'(DEBOUNCE_CYCLES - 1);
  localparam logic [23:0] INSTANT_STEP = 24'(`INSTANT_CYCLES / `STEP_COUNT);

  function automatic logic [9:0] gamma_of(input logic [5:0] idx);
    logic [9:0] t [0:62];
    t = '{10'd0, 10'd2, 10'd4, 10'd6, 10'd8, 10'd10, 10'd12, 10'd16,
          10'd20, 10'd24, 10'd28, 10'd32, 10'd36, 10'd42, 10'd48, 10'd54,
          10'd60, 10'd66, 10'd72, 10'd80, 10'd88, 10'd96, 10'd104, 10'd112,
          10'd120, 10'd130, 10'd140, 10'd150, 10'd160, 10'd170, 10'd180, 10'd194,
          10'd208, 10'd222, 10'd236, 10'd250, 10'd264, 10'd282, 10'd300, 10'd318,
          10'd336, 10'd354, 10'd372, 10'd394, 10'd416, 10'd438, 10'd460, 10'd482,
          10'd504, 10'd534, 10'd564, 10'd594, 10'd624, 10'd654, 10'd684, 10'd722,
          10'd760, 10'd798, 10'd836, 10'd874, 10'd914, 10'd956, 10'd1000};
    gamma_of = (idx > `LAST_STEP) ? t[62] : t[idx];
  endfunction

  function automatic logic [23:0] step_period(input logic [11:0] ms);
    logic [31:0] cyc;
    cyc = 32'(ms) * 32'(`TIME_UNIT_US * `CYCLES_PER_US / `STEP_COUNT);
    step_period = (ms == 12'h000) ? INSTANT_STEP : cyc[23:0];
  endfunction

  // Synchroniser
  logic        sync1_r;
  logic        sync2_r;
  logic        sync3_r;
  logic        stable_r;
  logic [20:0] db_cnt_r;
  logic        press;
  logic        agree;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
    end else begin
      sync1_r <= enable_n_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign agree = (sync2_r == sync3_r);

  // Debounce filter
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      stable_r <= 1'b1;
      db_cnt_r <= 21'h000000;
    end else if (!agree || sync3_r == stable_r) begin
      db_cnt_r <= 21'h000000;
    end else if (db_cnt_r == DB_LIMIT) begin
      stable_r <= sync3_r;
      db_cnt_r <= 21'h000000;
    end else begin
      db_cnt_r <= db_cnt_r + 21'h000001;
    end
  end

  assign press = agree && (sync3_r != stable_r) && (db_cnt_r == DB_LIMIT) && !sync3_r;

  // Toggle latch and ramp
  fade_ctrl_pkg::ramp_state_type state_r;
  fade_ctrl_pkg::ramp_state_type state_nxt;
  logic        on_r;
  logic [5:0]  idx_r;
  logic [5:0]  idx_nxt;
  logic [23:0] step_cnt_r;
  logic [23:0] period;
  logic        step_tick;

  assign period = (state_r == fade_ctrl_pkg::ST_DOWN) ? step_period(fade_out_time_input_i)
                                                      : step_period(fade_in_time_input_i);
  assign step_tick = (state_r != fade_ctrl_pkg::ST_IDLE) && (step_cnt_r + 24'h000001 >= period);

  always_comb begin
    state_nxt = state_r;
    idx_nxt = idx_r;
    case (state_r)
      fade_ctrl_pkg::ST_UP: begin
        if (step_tick && idx_r >= `LAST_STEP) begin
          state_nxt = fade_ctrl_pkg::ST_IDLE; // Reversal already at full scale
        end else if (step_tick) begin
          idx_nxt = idx_r + 6'h01;
          if (idx_r + 6'h01 == `LAST_STEP) begin
            state_nxt = fade_ctrl_pkg::ST_IDLE;
          end
        end
      end
      fade_ctrl_pkg::ST_DOWN: begin
        if (step_tick && idx_r == 6'h00) begin
          state_nxt = fade_ctrl_pkg::ST_IDLE; // Reversal already at zero
        end else if (step_tick) begin
          idx_nxt = idx_r - 6'h01;
          if (idx_r == 6'h01) begin
            state_nxt = fade_ctrl_pkg::ST_IDLE;
          end
        end
      end
      default: begin
      end
    endcase
    if (press) begin
      state_nxt = on_r ? fade_ctrl_pkg::ST_DOWN : fade_ctrl_pkg::ST_UP;
      idx_nxt = idx_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      on_r <= 1'b0;
      state_r <= fade_ctrl_pkg::ST_IDLE;
      idx_r <= 6'h00;
      step_cnt_r <= 24'h000000;
    end else begin
      if (press) begin
        on_r <= !on_r;
      end
      state_r <= state_nxt;
      idx_r <= idx_nxt;
      step_cnt_r <= (press || step_tick) ? 24'h000000 : step_cnt_r + 24'h000001;
    end
  end

  logic [9:0]  level_r;
  logic [19:0] drive_r;
  logic [9:0]  level_sel;

  // Direct dimming only when the toggle leaves the channel idle off
  assign level_sel = (!on_r && state_r == fade_ctrl_pkg::ST_IDLE && dim_direct_i) ? `LEVEL_FULL
                                                                                : gamma_of(idx_r);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      level_r <= 10'h000;
      drive_r <= 20'h00000;
    end else begin
      level_r <= level_sel;
      drive_r <= (20'(level_sel) * 20'(full_scale_current_input_i)) / 20'(`LEVEL_FULL);
    end
  end

  assign channel_on_o = on_r;
  assign ramp_busy_o = (state_r != fade_ctrl_pkg::ST_IDLE);
  assign level_o = level_r;
  assign drive_o = drive_r;

  property p_reset_off;
    @(posedge clk_sys_i) srst_i |=> (!channel_on_o && level_o == 10'h000);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("Not off after reset");

  property p_press_toggles;
    @(posedge clk_sys_i) disable iff (srst_i) press |=> (on_r != $past(on_r));
  endproperty
  a_press_toggles: assert property (p_press_toggles) else $error("Press did not toggle");

  property p_up_on_press;
    @(posedge clk_sys_i) disable iff (srst_i) (press && !on_r) |=> state_r == fade_ctrl_pkg::ST_UP;
  endproperty
  a_up_on_press: assert property (p_up_on_press) else $error("No up ramp");

  property p_down_on_press;
    @(posedge clk_sys_i) disable iff (srst_i) (press && on_r) |=> state_r == fade_ctrl_pkg::ST_DOWN;
  endproperty
  a_down_on_press: assert property (p_down_on_press) else $error("No down ramp");

  property p_reverse_keeps_idx;
    @(posedge clk_sys_i) disable iff (srst_i) (press && ramp_busy_o) |=> idx_r == $past(idx_r);
  endproperty
  a_reverse_keeps_idx: assert property (p_reverse_keeps_idx) else $error("Reversal jumped");

  property p_debounce_hold;
    @(posedge clk_sys_i) disable iff (srst_i) $changed(stable_r) |-> $past(agree, 1) && $past(db_cnt_r) == DB_LIMIT;
  endproperty
  a_debounce_hold: assert property (p_debounce_hold) else $error("Early accept");

  property p_one_step;
    @(posedge clk_sys_i) disable iff (srst_i)
      $changed(idx_r) |-> (idx_r == $past(idx_r) + 6'h01 || idx_r == $past(idx_r) - 6'h01);
  endproperty
  a_one_step: assert property (p_one_step) else $error("Step skipped");

  property p_idx_bound;
    @(posedge clk_sys_i) disable iff (srst_i) idx_r <= `LAST_STEP;
  endproperty
  a_idx_bound: assert property (p_idx_bound) else $error("Index past last step");

  property p_press_is_fall;
    @(posedge clk_sys_i) disable iff (srst_i) press |=> !stable_r;
  endproperty
  a_press_is_fall: assert property (p_press_is_fall) else $error("Press on release");

endmodule // fade_ctrl

// ### shared/fade_ctrl_defines.svh
/*
  Timing and table constants for the debounced toggle fade controller.
  Assumes a 50 MHz system clock.
*/
`ifndef FADE_CTRL_DEFINES_SVH
`define FADE_CTRL_DEFINES_SVH
`define CLK_FREQ_HZ        50000000
`define CYCLES_PER_US      50
`define DEBOUNCE_TIME_US   37000
`define DEBOUNCE_MIN_US    25000
`define DEBOUNCE_MAX_US    50000
`define DEBOUNCE_CYCLES    (`DEBOUNCE_TIME_US * `CYCLES_PER_US)
`define INSTANT_TIME_US    70
`define INSTANT_CYCLES     (`INSTANT_TIME_US * `CYCLES_PER_US)
`define STEP_COUNT         63
`define LAST_STEP          6'h3e
`define LEVEL_FULL         10'h3e8
`define TIME_UNIT_US       1000
`define DB_CNT_W           21
`define STEP_CNT_W         24
`endif

// ### shared/fade_ctrl_pkg.sv
/*
  Types for the debounced toggle fade controller.
  Assumes the defines header is compiled alongside.
*/
package fade_ctrl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_UP, ST_DOWN} ramp_state_type;
endpackage

// ### tb/button_model.sv
/* Momentary switch on the active-low enable.
   Assumes the bench calls stroke after reset. */
`timescale 1ns/100ps
module button_model (
  input  wire logic clk_sys_i,
  output logic      enable_n_o
);
  initial enable_n_o = 1'b1;
  // Chatter, then press and release, each held
  task automatic stroke(input int bounces, input int hold);
    repeat (bounces) begin
      @(posedge clk_sys_i) #1 enable_n_o = 1'b0;
      @(posedge clk_sys_i) #1 enable_n_o = 1'b1;
    end
    @(posedge clk_sys_i) #1 enable_n_o = 1'b0;
    repeat (hold) @(posedge clk_sys_i);
    #1 enable_n_o = 1'b1;
    repeat (hold) @(posedge clk_sys_i);
    #1;
  endtask
endmodule // button_model

// ### tb/testbench.sv
/* Self-checking bench for the toggle fade controller.
   Assumes a short debounce count; the bench drives the fade-in time. */
`timescale 1ns/100ps
`include "fade_ctrl_defines.svh"
module testbench;
  localparam int DB = 20;
  localparam int STEP_1MS = `TIME_UNIT_US * `CYCLES_PER_US / `STEP_COUNT;
  localparam int STEP_FAST = `INSTANT_CYCLES / `STEP_COUNT;
  logic        clk_sys_i    = 1'b0;
  logic        srst_i       = 1'b1;
  logic        dim_direct_i = 1'b0;
  logic        dim_en       = 1'b0;
  logic        enable_n;
  logic        channel_on_o;
  logic        ramp_busy_o;
  logic [9:0]  level_o;
  logic [9:0]  prev_level   = 10'h000;
  logic [9:0]  fs_r         = 10'h3e8;
  logic [19:0] drive_o;
  logic [7:0]  lfsr_r       = 8'h12;
  int          num_errors   = 0;
  int          checks_done  = 0;
  int          steps_seen   = 0;
  int          s0;
  int          cyc          = 0;
  int          last_chg     = 0;
  int          gap          = 0;
  logic [11:0] t_in         = 12'h000;
  logic        dim_seen;
  always #10 clk_sys_i = ~clk_sys_i;
  button_model btn (.clk_sys_i(clk_sys_i), .enable_n_o(enable_n));
  fade_ctrl #(.DEBOUNCE_CYCLES(DB)) dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .enable_n_i(enable_n),
    .dim_direct_i(dim_direct_i), .fade_in_time_input_i(t_in),
    .fade_out_time_input_i(12'h000), .full_scale_current_input_i(fs_r),
    .channel_on_o(channel_on_o), .ramp_busy_o(ramp_busy_o),
    .level_o(level_o), .drive_o(drive_o));
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Random dimming and level step count
  always @(posedge clk_sys_i) begin
    lfsr_r <= lfsr_next(lfsr_r);
    dim_direct_i <= #1 lfsr_r[0] & dim_en;
    cyc <= cyc + 1;
    if (level_o !== prev_level) begin
      steps_seen <= steps_seen + 1;
      gap <= cyc - last_chg;
      last_chg <= cyc;
    end
    prev_level <= level_o;
  end
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (ramp_busy_o !== 1'b0 && n < 8000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n == 8000) check(20'h1, 20'h0);
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    #1 srst_i = 1'b0;
    check({channel_on_o, ramp_busy_o, level_o}, 20'h0);
    check(drive_o, 20'h0);
    btn.stroke(0, DB / 2);
    check(channel_on_o, 1'b0);
    fs_r = {2'h3, lfsr_r};
    s0 = steps_seen;
    btn.stroke(3, DB * 2);
    check(channel_on_o, 1'b1);
    dim_en = 1'b1;
    wait_idle();
    check(level_o, 10'h3e8);
    check(20'(steps_seen - s0), 20'd62);
    check(20'(gap), 20'(STEP_FAST));
    check(drive_o, {10'h000, fs_r});
    dim_en = 1'b0;
    btn.stroke(0, DB * 2);
    repeat (600) @(posedge clk_sys_i);
    check({channel_on_o, ramp_busy_o}, 20'h1);
    s0 = steps_seen;
    btn.stroke(1, DB * 2);
    wait_idle();
    check({channel_on_o, level_o}, {9'h000, 1'b1, 10'h3e8});
    check(20'(steps_seen - s0 < 62), 20'h1);
    btn.stroke(2, DB * 2);
    wait_idle();
    check({channel_on_o, level_o}, 20'h0);
    check(drive_o, 20'h0);
    dim_en = 1'b1;
    repeat (8) begin
      @(posedge clk_sys_i);
      dim_seen = dim_direct_i;
      #2 check(level_o, dim_seen ? 10'h3e8 : 10'h000);
    end
    dim_en = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1 t_in = 12'h001;
    btn.stroke(0, DB * 2);
    repeat (3 * STEP_1MS) @(posedge clk_sys_i);
    check({channel_on_o, ramp_busy_o}, 20'h3);
    check(20'(gap), 20'(STEP_1MS));
    #1 srst_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 srst_i = 1'b0;
    check({channel_on_o, ramp_busy_o, level_o}, 20'h0);
    check(drive_o, 20'h0);
    test_done();
  end
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    num_errors++;
    test_done();
  end
endmodule // testbench
